// file: common/fsl_pkg.sv
package fsl_pkg;

    // -------------------------------------------------------------------
    // Command bytes of the serial register port.
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_GAIN_RD = 8'had;
    localparam logic [7:0] CMD_GAIN_WR = 8'hb6;
    localparam logic [7:0] CMD_PRESC_RD = 8'hbb;
    localparam logic [7:0] CMD_PRESC_WR = 8'hbc;
    localparam logic [7:0] CMD_REFDIV_RD = 8'hbf;
    localparam logic [7:0] CMD_REFDIV_WR = 8'hc0;
    localparam logic [7:0] CMD_LIMIT_RD = 8'hb1;
    localparam logic [7:0] CMD_LIMIT_WR = 8'hb8;
    localparam logic [7:0] CMD_RATE_RD = 8'hf0;
    localparam logic [7:0] CMD_RATE_WR = 8'hf1;
    localparam logic [7:0] CMD_PERIOD_RD = 8'hf2;

    // -------------------------------------------------------------------
    // Field positions and reset values.
    // -------------------------------------------------------------------
    localparam int GAIN_OPEN_BIT = 0;
    localparam int GAIN_CSENSE_BIT = 1;
    localparam int GAIN_KEEP_BIT = 7;
    localparam int GAIN_FLD_LO = 5;
    localparam logic [7:0] GAIN_RST = 8'h80;
    localparam logic [1:0] GAIN_FLD_RST = 2'h0;
    localparam logic [1:0] PRESC_RST = 2'h1;
    localparam logic [7:0] REFDIV_RST = 8'hff;
    localparam logic [7:0] REFDIV_MIN = 8'h7f;
    localparam logic [7:0] LIMIT_RST = 8'hff;
    localparam logic [2:0] RATE_RST = 3'h2;
    localparam logic [2:0] RATE_MAX = 3'h6;

    // Full-scale setpoints for 4, 5 and 6 bit gain, and open-loop top.
    localparam logic [6:0] FS_4BIT = 7'h10;
    localparam logic [6:0] FS_5BIT = 7'h20;
    localparam logic [6:0] FS_6BIT = 7'h3f;
    localparam logic [6:0] OPEN_FULL = 7'h40;

    // -------------------------------------------------------------------
    // Timing: internal oscillator tick and slowest update interval.
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 8415;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int UPD_SLOW_S = 16;
    localparam logic [17:0] UPD_SLOW_TICKS = 18'(UPD_SLOW_S * OSC_HZ);

    typedef struct packed {
        logic [7:0] gain;
        logic [1:0] presc;
        logic [7:0] refdiv;
        logic [7:0] limit;
        logic [2:0] rate;
    } fsl_cfg_t;

    typedef struct packed {
        logic fail;
        logic full_speed;
        logic therm_open;
        logic drv_en;
    } fsl_stat_t;

endpackage : fsl_pkg

// file: rtl/fsl_fan_loop.sv
`timescale 1ns/1ps
module fsl_fan_loop #(
    parameter int PERIOD_W = 8,
    parameter int OSC_DIV = fsl_pkg::OSC_DIV
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    input wire logic TACH_IN,
    input wire logic CUR_STEP,
    input wire logic DRV_OVER_150,
    input wire logic DRV_UNDER_140,
    input wire logic UPDATE_HALT,
    input wire logic [6:0] SPEED_SETPOINT,
    output logic [5:0] FAN_DAC,
    output logic UPDATE_TICK,
    output logic [1:0] GAIN_SEL,
    output fsl_pkg::fsl_stat_t STATUS
);

    // -------------------------------------------------------------------
    // State record.
    // -------------------------------------------------------------------
    typedef struct packed {
        fsl_pkg::fsl_cfg_t cfg;
        logic [11:0] osc_cnt;
        logic [7:0] ref_cnt;
        logic [6:0] acc;
        logic [5:0] updn;
        logic [2:0] pre_cnt;
        logic tach_d;
        logic cur_d;
        logic [PERIOD_W-1:0] per_cnt;
        logic [PERIOD_W-1:0] per_r;
        logic ovf;
        logic drv_off;
        logic [17:0] upd_cnt;
        logic upd_tick;
        logic [7:0] rd_data;
        logic rd_valid;
    } fsl_state_t;

    fsl_state_t st_r;
    fsl_state_t st_nxt;

    logic open_loop;
    logic osc_tick;
    logic ref_pulse;
    logic tach_edge;
    logic cur_edge;
    logic fb_raw;
    logic fb_pulse;
    logic up_pulse;
    logic per_full;
    logic [7:0] refdiv_eff;
    logic [6:0] fs_set;
    logic [7:0] acc_sum;
    logic [2:0] rate_eff;
    logic [17:0] upd_len;
    logic [2:0] pre_top;
    logic [PERIOD_W-1:0] limit_w;

    // -------------------------------------------------------------------
    // Decoded controls.
    // -------------------------------------------------------------------
    // The divider value is clamped at use, so a short value reads back
    // as written yet never speeds the reference beyond its ceiling.
    always_comb begin
        open_loop = st_r.cfg.gain[fsl_pkg::GAIN_OPEN_BIT];
        osc_tick = (st_r.osc_cnt == 12'(OSC_DIV - 1));
        refdiv_eff = (st_r.cfg.refdiv < fsl_pkg::REFDIV_MIN) ?
            fsl_pkg::REFDIV_MIN : st_r.cfg.refdiv;
        ref_pulse = osc_tick && (st_r.ref_cnt >= refdiv_eff - 8'h01);
        case (st_r.cfg.gain[6:5])
            2'b00: fs_set = fsl_pkg::FS_4BIT;
            2'b01: fs_set = fsl_pkg::FS_5BIT;
            default: fs_set = fsl_pkg::FS_6BIT;
        endcase
        acc_sum = {1'b0, st_r.acc} + {1'b0, SPEED_SETPOINT};
        up_pulse = ref_pulse && (acc_sum >= {1'b0, fs_set});
        tach_edge = TACH_IN && !st_r.tach_d;
        cur_edge = CUR_STEP && !st_r.cur_d;
        fb_raw = st_r.cfg.gain[fsl_pkg::GAIN_CSENSE_BIT] ?
            cur_edge : tach_edge;
        pre_top = 3'((4'h1 << st_r.cfg.presc) - 4'h1);
        // A count left above a newly lowered ratio must not swallow
        // pulses until it wraps, so the compare is an at-or-above test.
        fb_pulse = fb_raw && (st_r.pre_cnt >= pre_top) && !open_loop;
        per_full = &st_r.per_cnt;
        rate_eff = (st_r.cfg.rate > fsl_pkg::RATE_MAX) ?
            fsl_pkg::RATE_MAX : st_r.cfg.rate;
        upd_len = fsl_pkg::UPD_SLOW_TICKS >> rate_eff;
        limit_w = PERIOD_W'(st_r.cfg.limit);
    end

    // -------------------------------------------------------------------
    // Next-state logic.
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.upd_tick = 1'b0;
        st_nxt.tach_d = TACH_IN;
        st_nxt.cur_d = CUR_STEP;
        st_nxt.osc_cnt = osc_tick ? 12'h000 : st_r.osc_cnt + 12'h001;

        // Serial command port; unknown codes answer with zero.
        if (CMD_VALID) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data = 8'h00;
            case (CMD_CODE)
                fsl_pkg::CMD_GAIN_RD: st_nxt.rd_data = st_r.cfg.gain;
                fsl_pkg::CMD_GAIN_WR: begin
                    st_nxt.cfg.gain = CMD_WDATA;
                    if (!CMD_WDATA[fsl_pkg::GAIN_KEEP_BIT]) begin
                        st_nxt.cfg.gain[6:5] = fsl_pkg::GAIN_FLD_RST;
                    end
                end
                fsl_pkg::CMD_PRESC_RD:
                    st_nxt.rd_data = {6'h00, st_r.cfg.presc};
                fsl_pkg::CMD_PRESC_WR:
                    st_nxt.cfg.presc = CMD_WDATA[1:0];
                fsl_pkg::CMD_REFDIV_RD: st_nxt.rd_data = st_r.cfg.refdiv;
                fsl_pkg::CMD_REFDIV_WR: st_nxt.cfg.refdiv = CMD_WDATA;
                fsl_pkg::CMD_LIMIT_RD: st_nxt.rd_data = st_r.cfg.limit;
                fsl_pkg::CMD_LIMIT_WR: st_nxt.cfg.limit = CMD_WDATA;
                fsl_pkg::CMD_RATE_RD:
                    st_nxt.rd_data = {5'h00, st_r.cfg.rate};
                fsl_pkg::CMD_RATE_WR:
                    st_nxt.cfg.rate = CMD_WDATA[2:0];
                fsl_pkg::CMD_PERIOD_RD:
                    st_nxt.rd_data = 8'(st_r.per_r);
                default: st_nxt.rd_data = 8'h00;
            endcase
        end

        // Reference divider and rate multiplier toward the counter.
        if (osc_tick) begin
            st_nxt.ref_cnt = ref_pulse ? 8'h00 : st_r.ref_cnt + 8'h01;
        end
        if (ref_pulse) begin
            st_nxt.acc = up_pulse ? 7'(acc_sum - {1'b0, fs_set}) :
                7'(acc_sum);
        end

        // Feedback prescaler counts raw pulses of the selected source.
        if (fb_raw) begin
            st_nxt.pre_cnt = (st_r.pre_cnt >= pre_top) ? 3'h0 :
                st_r.pre_cnt + 3'h1;
        end

        // Saturating up/down counter; both at once cancel out.
        if (up_pulse && !fb_pulse && st_r.updn != 6'h3f) begin
            st_nxt.updn = st_r.updn + 6'h01;
        end else if (fb_pulse && !up_pulse && st_r.updn != 6'h00) begin
            st_nxt.updn = st_r.updn - 6'h01;
        end

        // Period measurement uses raw tach edges, never the prescaler.
        if (tach_edge) begin
            st_nxt.per_r = st_r.per_cnt;
            st_nxt.ovf = per_full;
            st_nxt.per_cnt = '0;
        end else if (osc_tick) begin
            if (per_full) begin
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.per_cnt = st_r.per_cnt + PERIOD_W'(1);
            end
        end

        // Thermal shutdown with hysteresis; the trip wins over recovery.
        if (DRV_OVER_150) begin
            st_nxt.drv_off = 1'b1;
        end else if (DRV_UNDER_140) begin
            st_nxt.drv_off = 1'b0;
        end

        // Update interval runs only while the autonomous halt is low.
        if (UPDATE_HALT) begin
            st_nxt.upd_cnt = 18'h00000;
        end else if (osc_tick) begin
            if (st_r.upd_cnt >= upd_len - 18'h00001) begin
                st_nxt.upd_cnt = 18'h00000;
                st_nxt.upd_tick = 1'b1;
            end else begin
                st_nxt.upd_cnt = st_r.upd_cnt + 18'h00001;
            end
        end
    end

    // -------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r <= '0;
            st_r.cfg.gain <= fsl_pkg::GAIN_RST;
            st_r.cfg.presc <= fsl_pkg::PRESC_RST;
            st_r.cfg.refdiv <= fsl_pkg::REFDIV_RST;
            st_r.cfg.limit <= fsl_pkg::LIMIT_RST;
            st_r.cfg.rate <= fsl_pkg::RATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Outputs.
    // -------------------------------------------------------------------
    // In open loop the setpoint is a plain DAC code; 40h and up pins it.
    always_comb begin
        if (open_loop) begin
            FAN_DAC = (SPEED_SETPOINT >= fsl_pkg::OPEN_FULL) ? 6'h3f :
                SPEED_SETPOINT[5:0];
        end else begin
            FAN_DAC = st_r.updn;
        end
        STATUS.fail = open_loop || st_r.ovf ||
            (st_r.per_r > limit_w);
        STATUS.full_speed = !open_loop && (st_r.updn == 6'h3f);
        STATUS.therm_open = open_loop;
        STATUS.drv_en = !st_r.drv_off;
        RD_DATA = st_r.rd_data;
        RD_VALID = st_r.rd_valid;
        UPDATE_TICK = st_r.upd_tick;
        GAIN_SEL = st_r.cfg.gain[6:5];
    end

    // -------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence gain_wr_s;
        CMD_VALID && CMD_CODE == fsl_pkg::CMD_GAIN_WR;
    endsequence

    gain_read_a: assert property (CMD_VALID && CMD_CODE ==
        fsl_pkg::CMD_GAIN_RD |=> RD_VALID && RD_DATA ==
        $past(st_r.cfg.gain))
        else $error("gain read returned wrong data");
    gain_clear_a: assert property (gain_wr_s and !CMD_WDATA[7] |=>
        GAIN_SEL == 2'b00)
        else $error("gain field not cleared");
    open_fail_a: assert property (STATUS.therm_open |->
        STATUS.fail && !STATUS.full_speed)
        else $error("open loop flags wrong");
    open_dac_a: assert property (open_loop &&
        SPEED_SETPOINT < fsl_pkg::OPEN_FULL |->
        FAN_DAC == SPEED_SETPOINT[5:0])
        else $error("open loop dac mismatch");
    limit_cmp_a: assert property (!open_loop && !st_r.ovf &&
        st_r.per_r > limit_w |-> STATUS.fail)
        else $error("period over limit not failed");
    period_load_a: assert property (tach_edge |=>
        st_r.per_r == $past(st_r.per_cnt) && st_r.per_cnt == '0)
        else $error("period not loaded");
    shutdown_a: assert property (DRV_OVER_150 |=> !STATUS.drv_en ##1
        (!STATUS.drv_en || $past(DRV_UNDER_140)))
        else $error("driver not held off");
    halt_upd_a: assert property (UPDATE_HALT [*2] |-> !UPDATE_TICK)
        else $error("update tick while halted");
    ref_rate_a: assert property (ref_pulse |=> !ref_pulse [*8])
        else $error("reference too fast");
    presc_a: assert property (fb_pulse |=> st_r.pre_cnt == 3'h0)
        else $error("prescaler ratio broken");
    updn_step_a: assert property (up_pulse && !fb_pulse &&
        st_r.updn != 6'h3f |=> st_r.updn == $past(st_r.updn) + 6'h01)
        else $error("up count not taken");

endmodule : fsl_fan_loop

// file: dv/fsl_fan_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------
// Fan with tachometer output, also used as the current-step source.
// -----------------------------------------------------------------------
module fsl_fan_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [15:0] period,
    input wire logic cur_only,
    output logic tach,
    output logic cur_step
);
    int cnt;

    // A stopped fan holds its tach line low, so no edge is ever seen.
    initial begin
        cnt = 0;
        tach = 1'b0;
        cur_step = 1'b0;
    end

    // Pulse is two clocks high, so a low cycle separates pulses whenever period is above 2.
    // A fan without tach output leaves only its current steps.
    always @(posedge clk) begin
        #1;
        if (!run) begin
            cnt = 0;
        end else begin
            cnt = (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
        end
        cur_step = run && (cnt < 2);
        tach = cur_step && !cur_only;
    end
endmodule : fsl_fan_model

// file: dv/fsl_fan_loop_tb.sv
`timescale 1ns/1ps
module fsl_fan_loop_tb;
    localparam int DIV = 2;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] rd_data;
    logic rd_valid;
    logic tach;
    logic cur_step;
    logic over_150 = 1'b0;
    logic under_140 = 1'b1;
    logic halt = 1'b0;
    logic [6:0] setpoint = 7'h00;
    logic [5:0] fan_dac;
    logic upd_tick;
    logic [1:0] gain_sel;
    fsl_pkg::fsl_stat_t status;
    logic fan_run = 1'b0;
    logic cur_only = 1'b0;
    logic [15:0] fan_period = 16'd400;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] rdv;
    logic seen;
    int k;
    int cnt;
    int sp;
    logic [7:0] rst_code [5] = '{8'had, 8'hbb, 8'hbf, 8'hb1, 8'hf0};
    logic [7:0] rst_val [5] = '{8'h80, 8'h01, 8'hff, 8'hff, 8'h02};

    // -------------------------------------------------------------------
    // Design, fan and clock.
    // -------------------------------------------------------------------
    fsl_fan_loop #(.PERIOD_W(8), .OSC_DIV(DIV)) i_dut (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(cmd_valid),
        .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .TACH_IN(tach), .CUR_STEP(cur_step),
        .DRV_OVER_150(over_150), .DRV_UNDER_140(under_140),
        .UPDATE_HALT(halt), .SPEED_SETPOINT(setpoint), .FAN_DAC(fan_dac),
        .UPDATE_TICK(upd_tick), .GAIN_SEL(gain_sel), .STATUS(status)
    );
    fsl_fan_model i_fan (.clk(clk_sys), .run(fan_run),
        .period(fan_period), .cur_only(cur_only), .tach(tach),
        .cur_step(cur_step));

    // Clock of 40 ns period.
    always #20 clk_sys = ~clk_sys;

    // -------------------------------------------------------------------
    // Shared tasks and expectations.
    // -------------------------------------------------------------------
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp);
        n_compared++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen_v, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    // One command; the answer pulse must follow in the next cycle.
    task automatic cmd(input logic [7:0] code, input logic [7:0] wd);
        cyc(1);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_wdata = wd;
        cyc(1);
        cmd_valid = 1'b0;
        chk(rd_valid, 8'h01);
        rdv = rd_data;
    endtask : cmd

    // Counts clocks up to the next tick; a hang ends the run.
    task automatic wait_tick(input int lim);
        cnt = 0;
        do begin
            cyc(1);
            cnt++;
        end while (upd_tick !== 1'b1 && cnt < lim);
        if (cnt >= lim) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_tick

    function automatic int exp_int(input int code);
        return ((16 * 8415) >> code) * DIV;
    endfunction : exp_int

    // -------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------
    initial begin
        void'($urandom(40));
        cyc(10);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            cmd(rst_code[i], 8'h00);
            chk(rdv, rst_val[i]);
        end
        cmd(8'h5a, 8'h33);
        chk(rdv, 8'h00);
        // Gain codes 0 to 2, then a write with the keep bit low.
        for (int g = 0; g < 3; g++) begin
            cmd(fsl_pkg::CMD_GAIN_WR, 8'h80 | 8'(g << 5));
            cmd(fsl_pkg::CMD_GAIN_RD, 8'h00);
            chk(rdv, 8'h80 | 8'(g << 5));
            chk(8'(gain_sel), 8'(g));
        end
        cmd(fsl_pkg::CMD_GAIN_WR, 8'h40);
        chk(8'(gain_sel), 8'h00);
        cmd(fsl_pkg::CMD_GAIN_WR, 8'h80);
        for (int i = 0; i < 4; i++) begin
            cmd(fsl_pkg::CMD_PRESC_WR, 8'(i));
            cmd(fsl_pkg::CMD_PRESC_RD, 8'h00);
            chk(rdv, 8'(i));
        end
        k = 127 + $urandom % 129;
        cmd(fsl_pkg::CMD_REFDIV_WR, 8'(k));
        cmd(fsl_pkg::CMD_REFDIV_RD, 8'h00);
        chk(rdv, 8'(k));
        cmd(fsl_pkg::CMD_REFDIV_WR, 8'h10);
        cmd(fsl_pkg::CMD_REFDIV_RD, 8'h00);
        chk(rdv, 8'h10);
        // Update interval: upper bits ignored, codes 6 and 5, then halt.
        cmd(fsl_pkg::CMD_RATE_WR, 8'hfe);
        cmd(fsl_pkg::CMD_RATE_RD, 8'h00);
        chk(rdv, 8'h06);
        wait_tick(40000);
        wait_tick(40000);
        chk(8'(cnt == exp_int(6)), 8'h01);
        cmd(fsl_pkg::CMD_RATE_WR, 8'h05);
        wait_tick(40000);
        wait_tick(40000);
        chk(8'(cnt == exp_int(5)), 8'h01);
        cmd(fsl_pkg::CMD_RATE_WR, 8'h06);
        halt = 1'b1;
        seen = 1'b0;
        repeat (9000) begin
            cyc(1);
            seen = seen | (upd_tick === 1'b1);
        end
        chk(8'(seen), 8'h00);
        halt = 1'b0;
        // Period measurement and limit compare with a running fan.
        k = 40 + $urandom % 150;
        fan_period = 16'(k * DIV);
        fan_run = 1'b1;
        cyc(3 * k * DIV);
        cmd(fsl_pkg::CMD_PERIOD_RD, 8'h00);
        chk(8'(int'(rdv) >= k - 1 && int'(rdv) <= k + 1), 8'h01);
        cmd(fsl_pkg::CMD_LIMIT_WR, 8'(k - 10));
        cyc(2 * k * DIV);
        chk(8'(status.fail), 8'h01);
        cmd(fsl_pkg::CMD_LIMIT_WR, 8'(k + 10));
        cyc(2 * k * DIV);
        chk(8'(status.fail), 8'h00);
        cmd(fsl_pkg::CMD_PRESC_WR, 8'h03);
        cyc(3 * k * DIV);
        cmd(fsl_pkg::CMD_PERIOD_RD, 8'h00);
        chk(8'(int'(rdv) >= k - 1 && int'(rdv) <= k + 1), 8'h01);
        // A stopped fan overflows the period counter.
        cmd(fsl_pkg::CMD_LIMIT_WR, 8'hff);
        fan_run = 1'b0;
        cyc(300 * DIV);
        chk(8'(status.fail), 8'h01);
        fan_run = 1'b1;
        cyc(3 * k * DIV);
        chk(8'(status.fail), 8'h00);
        // Closed loop, fan stopped: a full-scale setpoint makes every
        // reference pulse an up count; the short divider acts as 127.
        fan_run = 1'b0;
        setpoint = fsl_pkg::FS_4BIT;
        cnt = 0;
        do begin
            cyc(1);
            cnt++;
        end while (status.full_speed !== 1'b1 && cnt < 70 * 127 * DIV);
        if (cnt >= 70 * 127 * DIV) begin
            n_errors++;
            end_sim();
        end
        sp = cnt - 62 * 127 * DIV;
        chk(8'(sp >= 0 && sp <= 127 * DIV + 2), 8'h01);
        chk(8'(fan_dac), 8'h3f);
        chk(8'(status.full_speed), 8'h01);
        // Current sense: steps count down only once that source is chosen.
        setpoint = 7'h00;
        cmd(fsl_pkg::CMD_PRESC_WR, 8'h00);
        cur_only = 1'b1;
        fan_run = 1'b1;
        cyc(4 * k * DIV);
        chk(8'(fan_dac), 8'h3f);
        cmd(fsl_pkg::CMD_GAIN_WR, 8'h82);
        cyc(4 * k * DIV);
        chk(8'(fan_dac >= 6'h3a && fan_dac <= 6'h3c), 8'h01);
        sp = int'(fan_dac);
        cmd(fsl_pkg::CMD_PRESC_WR, 8'h01);
        cyc(8 * k * DIV);
        sp = sp - int'(fan_dac);
        chk(8'(sp >= 3 && sp <= 5), 8'h01);
        cur_only = 1'b0;
        // Open loop: setpoint drives the DAC, tach is ignored.
        cmd(fsl_pkg::CMD_GAIN_WR, 8'h81);
        chk(8'(status.therm_open), 8'h01);
        chk(8'(status.fail), 8'h01);
        for (int i = 0; i < 8; i++) begin
            sp = (i < 4) ? $urandom % 64 : 64 + $urandom % 64;
            setpoint = 7'(sp);
            cyc(1);
            chk(8'(fan_dac), (sp < 64) ? 8'(sp) : 8'h3f);
        end
        // Driver thermal shutdown with hysteresis.
        over_150 = 1'b1;
        under_140 = 1'b0;
        cyc(2);
        chk(8'(status.drv_en), 8'h00);
        over_150 = 1'b0;
        cyc(2);
        chk(8'(status.drv_en), 8'h00);
        under_140 = 1'b1;
        cyc(2);
        chk(8'(status.drv_en), 8'h01);
        end_sim();
    end
endmodule : fsl_fan_loop_tb
